/* File: shared/acf_pkg.sv */
// Constants, register map and types for the accelerometer output block.
// Assumes a single 40 MHz system clock and an 8-bit register port.
package acf_pkg;

	localparam int ADDR_W    = 6;
	localparam int DATA_W    = 8;
	localparam int AXIS_W    = 13;
	localparam int WORD_W    = 16;
	localparam int JUST_PAD  = WORD_W - AXIS_W;
	localparam int SMP_W     = 3 * AXIS_W;
	localparam int BUF_DEPTH = 32;
	localparam int CNT_W     = 6;

	// Register offsets
	localparam logic [ADDR_W-1:0] ADDR_INT_EN  = 6'h2E;
	localparam logic [ADDR_W-1:0] ADDR_INT_RTE = 6'h2F;
	localparam logic [ADDR_W-1:0] ADDR_INT_SRC = 6'h30;
	localparam logic [ADDR_W-1:0] ADDR_FORMAT  = 6'h31;
	localparam logic [ADDR_W-1:0] ADDR_X_LO    = 6'h32;
	localparam logic [ADDR_W-1:0] ADDR_X_HI    = 6'h33;
	localparam logic [ADDR_W-1:0] ADDR_Y_LO    = 6'h34;
	localparam logic [ADDR_W-1:0] ADDR_Y_HI    = 6'h35;
	localparam logic [ADDR_W-1:0] ADDR_Z_LO    = 6'h36;
	localparam logic [ADDR_W-1:0] ADDR_Z_HI    = 6'h37;
	localparam logic [ADDR_W-1:0] ADDR_BUF_CTL = 6'h38;
	localparam logic [ADDR_W-1:0] ADDR_BUF_STS = 6'h39;

	// Event bit positions, shared by enable, routing and flag registers
	localparam int EV_DRDY  = 7;
	localparam int EV_ACT   = 4;
	localparam int EV_INACT = 3;
	localparam int EV_WMARK = 1;
	localparam int EV_OVRUN = 0;
	localparam logic [DATA_W-1:0] EV_MASK = 8'h9B;

	// Output format fields
	localparam int FMT_SELFTEST = 7;
	localparam int FMT_WIRE3    = 6;
	localparam int FMT_POL      = 5;
	localparam int FMT_JUST     = 2;
	localparam logic [DATA_W-1:0] FMT_WR_MASK = 8'hE4;
	localparam logic [DATA_W-1:0] FMT_FIXED   = 8'h0B;

	// Buffer control and status fields
	localparam int CTL_MODE_HI = 7;
	localparam int CTL_MODE_LO = 6;
	localparam int CTL_TRIG    = 5;
	localparam int CTL_SMP_HI  = 4;
	localparam int STS_TRIG    = 7;

	// Reset values
	localparam logic [DATA_W-1:0] RST_INT_EN  = 8'h00;
	localparam logic [DATA_W-1:0] RST_INT_RTE = 8'h00;
	localparam logic [DATA_W-1:0] RST_FORMAT  = 8'h00;
	localparam logic [DATA_W-1:0] RST_BUF_CTL = 8'h00;
	localparam logic [DATA_W-1:0] RST_ZERO    = 8'h00;
	localparam logic              IRQ_IDLE    = 1'b1;

	typedef enum logic [1:0] {
		MODE_BYPASS  = 2'b00,
		MODE_FIFO    = 2'b01,
		MODE_STREAM  = 2'b10,
		MODE_TRIGGER = 2'b11
	} acf_mode_e;

	typedef struct packed {
		logic [AXIS_W-1:0] x;
		logic [AXIS_W-1:0] y;
		logic [AXIS_W-1:0] z;
	} acf_sample_s;

	// Left: MSB aligned, zero filled; right: sign extended
	function automatic logic [WORD_W-1:0] acf_fmt_word(
		input logic [AXIS_W-1:0] v,
		input logic              left
	);
		return left ? {v, {JUST_PAD{1'b0}}} : {{JUST_PAD{v[AXIS_W-1]}}, v};
	endfunction

endpackage

/* File: shared/acf_fifo_if.sv */
// Valid/ready carrier between the output block and its sample buffer.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface acf_fifo_if #(
	parameter int WIDTH = 39,
	parameter int CW    = 6
);
	logic             in_valid;
	logic             in_ready;
	logic [WIDTH-1:0] in_data;
	logic             out_valid;
	logic             out_ready;
	logic [WIDTH-1:0] out_data;
	logic [CW-1:0]    count;

	modport src (
		output in_valid, in_data, out_ready,
		input  in_ready, out_valid, out_data, count
	);
	modport store (
		input  in_valid, in_data, out_ready,
		output in_ready, out_valid, out_data, count
	);
endinterface

/* File: logic/acf_fifo.sv */
// Sample buffer: circular memory with registered read data.
// Assumes the drainer may pop while full to make room for a push.
`timescale 1ns/1ps
module acf_fifo
	import acf_pkg::*;
#(
	parameter int WIDTH = SMP_W,
	parameter int DEPTH = BUF_DEPTH
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	acf_fifo_if.store fif
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW-1:0]    rd_ptr_next;
	logic [CW-1:0]    count_reg;
	logic [WIDTH-1:0] rdata_reg;

	wire push = fif.in_valid && fif.in_ready;
	wire pop  = fif.out_valid && fif.out_ready;

	assign fif.in_ready  = (count_reg != CW'(DEPTH)) || fif.out_ready;
	assign fif.out_valid = (count_reg != '0);
	assign fif.out_data  = rdata_reg;
	assign fif.count     = CNT_W'(count_reg);
	assign rd_ptr_next   = pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr_reg] <= fif.in_data;
		end
	end

	// Forward the write when it lands on the next head
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			rdata_reg  <= '0;
		end else begin
			wr_ptr_reg <= push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
			rd_ptr_reg <= rd_ptr_next;
			count_reg  <= CW'(count_reg + push - pop);
			rdata_reg  <= (push && wr_ptr_reg == rd_ptr_next) ?
				fif.in_data : mem[rd_ptr_next];
		end
	end

endmodule // acf_fifo

/* File: logic/acf_irq_route.sv */
// Interrupt gating, routing and pin polarity.
// Assumes flags, enables and routing come from registers of the caller.
`timescale 1ns/1ps
module acf_irq_route
	import acf_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic [DATA_W-1:0] flags,
	input  wire logic [DATA_W-1:0] enable,
	input  wire logic [DATA_W-1:0] routing,
	input  wire logic              active_high,
	output logic                   pin_one_raw,
	output logic                   pin_two_raw,
	output logic                   irq_pin_one,
	output logic                   irq_pin_two
);
	wire [DATA_W-1:0] live = flags & enable & EV_MASK;

	assign pin_one_raw = |(live & ~routing);
	assign pin_two_raw = |(live & routing);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_pin_one <= IRQ_IDLE;
			irq_pin_two <= IRQ_IDLE;
		end else begin
			irq_pin_one <= pin_one_raw ~^ active_high;
			irq_pin_two <= pin_two_raw ~^ active_high;
		end
	end

endmodule // acf_irq_route

/* File: logic/acf_output_regs.sv */
// Output side of the accelerometer: event flags, interrupt pins, output
// format, axis bytes and the 32-entry sample buffer with its modes.
// Assumes a register port driven by the serial engines, one access per
// strobe, and xfer_active high for the whole of each host transaction.
`timescale 1ns/1ps
module acf_output_regs
	import acf_pkg::*;
#(
	parameter int DEPTH = BUF_DEPTH
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic              reg_wr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	input  wire logic              xfer_active,
	input  wire logic              smp_valid,
	output logic                   smp_ready,
	input  wire logic [AXIS_W-1:0] smp_x,
	input  wire logic [AXIS_W-1:0] smp_y,
	input  wire logic [AXIS_W-1:0] smp_z,
	input  wire logic              act_event,
	input  wire logic              inact_event,
	output logic                   irq_pin_one,
	output logic                   irq_pin_two,
	output logic                   self_test_en,
	output logic                   three_wire_mode
);
	// Register state
	logic [DATA_W-1:0] int_en_reg;
	logic [DATA_W-1:0] int_rte_reg;
	logic [DATA_W-1:0] fmt_reg;
	logic [DATA_W-1:0] ctl_reg;
	logic [DATA_W-1:0] flag_reg;
	logic [DATA_W-1:0] flag_next;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic              trig_reg;
	logic              trig_next;
	acf_sample_s       out_reg;
	acf_sample_s       out_next;
	logic              out_valid_reg;
	logic              out_valid_next;
	logic              pop_pend_reg;
	logic              pop_pend_next;

	// Buffer control
	logic              push;
	logic              drop;
	logic              lost;
	logic              pin_one_raw;
	logic              pin_two_raw;

	acf_fifo_if #(.WIDTH(SMP_W), .CW(CNT_W)) fif ();

	acf_fifo #(
		.WIDTH (SMP_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.fif     (fif.store)
	);

	acf_irq_route u_irq (
		.clk_sys     (clk_sys),
		.rst_n       (rst_n),
		.flags       (flag_reg),
		.enable      (int_en_reg),
		.routing     (int_rte_reg),
		.active_high (fmt_reg[FMT_POL]),
		.pin_one_raw (pin_one_raw),
		.pin_two_raw (pin_two_raw),
		.irq_pin_one (irq_pin_one),
		.irq_pin_two (irq_pin_two)
	);

	// Address decode
	wire wr_int_en  = reg_wr && (reg_addr == ADDR_INT_EN);
	wire wr_int_rte = reg_wr && (reg_addr == ADDR_INT_RTE);
	wire wr_fmt     = reg_wr && (reg_addr == ADDR_FORMAT);
	wire wr_ctl     = reg_wr && (reg_addr == ADDR_BUF_CTL);
	wire rd_flags   = reg_rd && (reg_addr == ADDR_INT_SRC);
	wire rd_data    = reg_rd && (reg_addr >= ADDR_X_LO) &&
		(reg_addr <= ADDR_Z_HI);

	// Control fields
	wire acf_mode_e       mode     = acf_mode_e'(
		ctl_reg[CTL_MODE_HI:CTL_MODE_LO]);
	wire [CTL_SMP_HI:0]   samples  = ctl_reg[CTL_SMP_HI:0];
	wire                  trig_sel = ctl_reg[CTL_TRIG];
	wire                  just_l   = fmt_reg[FMT_JUST];
	wire [CNT_W-1:0]      fifo_cnt = fif.count;
	wire                  fifo_full = (fifo_cnt == CNT_W'(DEPTH));
	wire [CNT_W-1:0]      smp_lvl  = CNT_W'(samples);

	// A read inside a burst pops once, after the burst ends
	wire pop_now = pop_pend_reg && !xfer_active;
	assign pop_pend_next = (pop_pend_reg && !pop_now) || rd_data;

	// Acceptance per buffer mode
	always_comb begin
		push = 1'b0;
		drop = 1'b0;
		lost = 1'b0;
		case (mode)
			MODE_BYPASS: begin
				push = 1'b0;
			end
			MODE_FIFO: begin
				push = smp_valid;
				lost = smp_valid && !fif.in_ready;
			end
			MODE_STREAM: begin
				push = smp_valid;
				drop = smp_valid && fifo_full;
				lost = drop;
			end
			MODE_TRIGGER: begin
				push = smp_valid;
				if (!trig_reg) begin
					// Keep only the requested pre-trigger depth
					drop = smp_valid && fif.out_valid &&
						(fifo_cnt >= smp_lvl || fifo_full);
				end else begin
					lost = smp_valid && !fif.in_ready;
				end
			end
			default: begin
				push = 1'b0;
			end
		endcase
	end

	// Output stage loads only outside a host transaction
	wire byp_load = (mode == MODE_BYPASS) && smp_valid && !xfer_active;
	wire buf_load = (mode != MODE_BYPASS) && fif.out_valid &&
		(!out_valid_reg || pop_now) && !xfer_active;
	wire new_data = byp_load || buf_load;
	wire byp_lost = byp_load && out_valid_reg && !pop_now;

	assign fif.in_valid  = push;
	assign fif.in_data   = {smp_x, smp_y, smp_z};
	assign fif.out_ready = buf_load || drop;
	assign smp_ready     = (mode == MODE_BYPASS) ? !xfer_active : 1'b1;

	assign out_next = byp_load ? acf_sample_s'({smp_x, smp_y, smp_z}) :
		buf_load ? acf_sample_s'(fif.out_data) : out_reg;
	assign out_valid_next = new_data ? 1'b1 :
		(pop_now ? 1'b0 : out_valid_reg);

	// Watermark: level reached in fifo or stream mode, or a samples value of zero in any mode
	wire wm_cond = (samples == '0) ||
		((mode == MODE_FIFO || mode == MODE_STREAM) &&
		fifo_cnt >= smp_lvl);

	// Event flags; a set in the clearing cycle wins
	always_comb begin
		flag_next           = RST_ZERO;
		flag_next[EV_DRDY]  = new_data ||
			(flag_reg[EV_DRDY] && !pop_now);
		flag_next[EV_WMARK] = wm_cond ||
			(flag_reg[EV_WMARK] && !pop_now);
		flag_next[EV_OVRUN] = lost || byp_lost ||
			(flag_reg[EV_OVRUN] && !pop_now);
		flag_next[EV_ACT]   = act_event ||
			(flag_reg[EV_ACT] && !rd_flags);
		flag_next[EV_INACT] = inact_event ||
			(flag_reg[EV_INACT] && !rd_flags);
	end

	// Trigger latches on the selected pin's event, cleared by a control write
	wire trig_hit = (mode == MODE_TRIGGER) &&
		(trig_sel ? pin_two_raw : pin_one_raw);
	assign trig_next = trig_hit || (trig_reg && !wr_ctl);

	// Read data selection
	wire [WORD_W-1:0] x_word = acf_fmt_word(out_reg.x, just_l);
	wire [WORD_W-1:0] y_word = acf_fmt_word(out_reg.y, just_l);
	wire [WORD_W-1:0] z_word = acf_fmt_word(out_reg.z, just_l);
	wire [CNT_W-1:0]  entries = CNT_W'(fifo_cnt + out_valid_reg);
	wire [DATA_W-1:0] fmt_rd  = (fmt_reg & FMT_WR_MASK) | FMT_FIXED;
	wire [DATA_W-1:0] sts_rd  = {trig_reg, 1'b0, entries};

	wire [DATA_W-1:0] rd_sel =
		(reg_addr == ADDR_INT_EN)  ? int_en_reg :
		(reg_addr == ADDR_INT_RTE) ? int_rte_reg :
		(reg_addr == ADDR_INT_SRC) ? flag_reg :
		(reg_addr == ADDR_FORMAT)  ? fmt_rd :
		(reg_addr == ADDR_X_LO)    ? x_word[DATA_W-1:0] :
		(reg_addr == ADDR_X_HI)    ? x_word[WORD_W-1:DATA_W] :
		(reg_addr == ADDR_Y_LO)    ? y_word[DATA_W-1:0] :
		(reg_addr == ADDR_Y_HI)    ? y_word[WORD_W-1:DATA_W] :
		(reg_addr == ADDR_Z_LO)    ? z_word[DATA_W-1:0] :
		(reg_addr == ADDR_Z_HI)    ? z_word[WORD_W-1:DATA_W] :
		(reg_addr == ADDR_BUF_CTL) ? ctl_reg :
		(reg_addr == ADDR_BUF_STS) ? sts_rd : RST_ZERO;
	assign rdata_next = reg_rd ? rd_sel : rdata_reg;

	assign reg_rdata       = rdata_reg;
	assign self_test_en    = fmt_reg[FMT_SELFTEST];
	assign three_wire_mode = fmt_reg[FMT_WIRE3];

	// Configuration registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			int_en_reg  <= RST_INT_EN;
			int_rte_reg <= RST_INT_RTE;
			fmt_reg     <= RST_FORMAT;
			ctl_reg     <= RST_BUF_CTL;
		end else begin
			int_en_reg  <= wr_int_en ? reg_wdata : int_en_reg;
			int_rte_reg <= wr_int_rte ? reg_wdata : int_rte_reg;
			fmt_reg     <= wr_fmt ? (reg_wdata & FMT_WR_MASK) :
				fmt_reg;
			ctl_reg     <= wr_ctl ? reg_wdata : ctl_reg;
		end
	end

	// Status, output stage and read data
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			flag_reg      <= RST_ZERO;
			trig_reg      <= 1'b0;
			out_reg       <= '0;
			out_valid_reg <= 1'b0;
			pop_pend_reg  <= 1'b0;
			rdata_reg     <= RST_ZERO;
		end else begin
			flag_reg      <= flag_next;
			trig_reg      <= trig_next;
			out_reg       <= out_next;
			out_valid_reg <= out_valid_next;
			pop_pend_reg  <= pop_pend_next;
			rdata_reg     <= rdata_next;
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	sequence s_burst_cont;
		xfer_active ##1 xfer_active;
	endsequence

	sequence s_zero_write;
		wr_ctl && (reg_wdata[CTL_SMP_HI:0] == '0);
	endsequence

	a_fifo_mode_stop: assert property (
		(mode == MODE_FIFO && fifo_full && !fif.out_ready)
		|=> (fifo_cnt == CNT_W'(DEPTH)))
		else $error("fifo mode took a sample while full");

	a_stream_keeps_full: assert property (
		(mode == MODE_STREAM && fifo_full && smp_valid)
		|=> (fifo_cnt == CNT_W'(DEPTH)) && flag_reg[EV_OVRUN])
		else $error("stream mode did not overwrite oldest");

	a_pin_one_or: assert property (
		1'b1 |=> irq_pin_one == (
		$past(|(flag_reg & int_en_reg & ~int_rte_reg & EV_MASK))
		~^ $past(fmt_reg[FMT_POL])))
		else $error("pin one is not the OR of its events");

	a_pin_two_route: assert property (
		1'b1 |=> irq_pin_two == (
		$past(|(flag_reg & int_en_reg & int_rte_reg & EV_MASK))
		~^ $past(fmt_reg[FMT_POL])))
		else $error("pin two routing wrong");

	a_ovrun_unmasked: assert property (
		(lost || byp_lost) |=> flag_reg[EV_OVRUN])
		else $error("overrun flag not set");

	a_src_read_clear: assert property (
		(rd_flags && !act_event) |=> !flag_reg[EV_ACT])
		else $error("activity flag survived flag read");

	a_src_read_keeps: assert property (
		(rd_flags && flag_reg[EV_DRDY] && !pop_now)
		|=> flag_reg[EV_DRDY])
		else $error("sample ready cleared by flag read");

	a_zero_wmark: assert property (
		s_zero_write |=> ##1 flag_reg[EV_WMARK])
		else $error("zero samples did not set watermark");

	a_burst_hold: assert property (
		s_burst_cont |-> $stable(out_reg))
		else $error("axis data changed inside a burst");

	sequence s_pre_trig_full;
		mode == MODE_TRIGGER && !trig_reg && smp_valid &&
			fif.out_valid && fifo_cnt >= smp_lvl;
	endsequence

	a_pre_trig_depth: assert property (
		s_pre_trig_full |=> $stable(fifo_cnt))
		else $error("pre-trigger depth not kept");

	a_trig_latch: assert property (
		(mode == MODE_TRIGGER && (trig_sel ? pin_two_raw : pin_one_raw))
		|=> trig_reg)
		else $error("trigger event not latched");

	a_pop_empties: assert property (
		(pop_now && !fif.out_valid && !byp_load) |=> !out_valid_reg)
		else $error("output stage kept after pop");

endmodule // acf_output_regs

/* File: tb/acf_host_model.sv */
// Host model: register-port master standing in for the serial engines.
// Assumes read data appears one cycle after the strobe edge.
`timescale 1ns/1ps
module acf_host_model
	import acf_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic [DATA_W-1:0] reg_rdata,
	output logic      [ADDR_W-1:0] reg_addr,
	output logic                   reg_wr,
	output logic      [DATA_W-1:0] reg_wdata,
	output logic                   reg_rd,
	output logic                   xfer_active
);
	initial begin
		reg_addr = '0;
		reg_wr = 1'b0;
		reg_wdata = '0;
		reg_rd = 1'b0;
		xfer_active = 1'b0;
	end
	task automatic start();
		@(posedge clk_sys);
		#1;
		xfer_active = 1'b1;
	endtask
	// Released lines show the inverse so no stale value passes for data
	task automatic stop();
		@(posedge clk_sys);
		#1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
		xfer_active = 1'b0;
	endtask
	task automatic write(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		start();
		@(posedge clk_sys);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		stop();
	endtask
	// All bytes of a sample in one transaction
	task automatic burst(input logic [ADDR_W-1:0] a, input int n,
		output logic [47:0] b);
		start();
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			#1;
			if (i > 0) b[8*(i-1) +: 8] = reg_rdata;
			reg_addr = a + ADDR_W'(i);
			reg_rd = 1'b1;
		end
		stop();
		b[8*(n-1) +: 8] = reg_rdata;
	endtask
endmodule // acf_host_model

/* File: tb/testbench.sv */
// Self-checking bench: registers, pins, formatting and buffer modes.
// Assumes the host model owns the register port, the bench the samples.
`timescale 1ns/1ps
module testbench
	import acf_pkg::*;
;
	localparam int D = 4;
	logic              clk_sys = 1'b0;
	logic              rst_n = 1'b0;
	logic [ADDR_W-1:0] reg_addr;
	logic              reg_wr, reg_rd, xfer_active, smp_valid, smp_ready;
	logic [DATA_W-1:0] reg_wdata, reg_rdata;
	logic [AXIS_W-1:0] smp_x, smp_y, smp_z;
	logic              act_event, inact_event, irq_pin_one, irq_pin_two;
	logic              self_test_en, three_wire_mode;
	logic [31:0]       seed = 32'hef68_593c;
	int                mismatches = 0;
	int                total_checks = 0;
	acf_sample_s       q[$];
	acf_sample_s       s;

	always #12.5 clk_sys = ~clk_sys;

	acf_output_regs #(.DEPTH(D)) acf_output_regs_i (.clk_sys(clk_sys),
		.rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.xfer_active(xfer_active), .smp_valid(smp_valid),
		.smp_ready(smp_ready), .smp_x(smp_x), .smp_y(smp_y), .smp_z(smp_z),
		.act_event(act_event), .inact_event(inact_event),
		.irq_pin_one(irq_pin_one), .irq_pin_two(irq_pin_two),
		.self_test_en(self_test_en), .three_wire_mode(three_wire_mode));
	acf_host_model acf_host_model_i (.clk_sys(clk_sys),
		.reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .xfer_active(xfer_active));

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic acf_sample_s smp();
		seed = lfsr(seed);
		return SMP_W'({seed, lfsr(seed)});
	endfunction
	function automatic logic [15:0] word(input logic [12:0] v, input logic l);
		if (l) return {v, 3'b000};
		return {{3{v[12]}}, v};
	endfunction
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		acf_host_model_i.write(a, d);
		@(posedge clk_sys);
		#1;
	endtask
	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] m,
		input logic [7:0] e);
		logic [47:0] b;
		acf_host_model_i.burst(a, 1, b);
		check(b[7:0] & m, e);
	endtask
	task automatic burst_chk(input acf_sample_s v, input logic l);
		logic [47:0] b;
		acf_host_model_i.burst(ADDR_X_LO, 6, b);
		check(b, {word(v.z, l), word(v.y, l), word(v.x, l)});
	endtask
	task automatic push(input acf_sample_s v);
		@(posedge clk_sys);
		#1;
		{smp_x, smp_y, smp_z} = v;
		smp_valid = 1'b1;
		@(posedge clk_sys);
		#1;
		smp_valid = 1'b0;
	endtask
	task automatic fill(input int n);
		for (int i = 0; i < n; i++) begin
			s = smp();
			push(s);
			q.push_back(s);
		end
	endtask
	task automatic ev(input logic a, input logic b);
		@(posedge clk_sys);
		#1;
		act_event = a;
		inact_event = b;
		@(posedge clk_sys);
		#1;
		act_event = 1'b0;
		inact_event = 1'b0;
	endtask
	task automatic drain();
		int n;
		n = q.size();
		for (int i = 0; i < n; i++) begin
			rdc(ADDR_BUF_STS, 8'h3f, 8'(n - i));
			burst_chk(q.pop_front(), 1'b0);
		end
		rdc(ADDR_BUF_STS, 8'h3f, 8'h00);
	endtask

	// Watchdog: the whole sequence takes a few hundred cycles
	initial begin
		#500_000;
		mismatches++;
		conclude();
	end

	initial begin
		{smp_valid, act_event, inact_event} = 3'b000;
		{smp_x, smp_y, smp_z} = '0;
		repeat (8) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		check({irq_pin_one, irq_pin_two}, 2'b11);
		check(smp_ready, 1'b1);
		rdc(ADDR_FORMAT, 8'hff, 8'h0b);
		rdc(ADDR_INT_EN, 8'hff, 8'h00);
		rdc(6'h3a, 8'hff, 8'h00);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			wr(ADDR_FORMAT, seed[7:0]);
			rdc(ADDR_FORMAT, 8'hff, (seed[7:0] & 8'he4) | 8'h0b);
			check({self_test_en, three_wire_mode}, seed[7:6]);
		end
		$display("test format done");
		wr(ADDR_FORMAT, 8'h20);
		ev(1'b1, 1'b1);
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			wr(ADDR_INT_RTE, seed[15:8]);
			wr(ADDR_INT_EN, seed[7:0] & 8'h18);
			check(irq_pin_one, |(seed[7:0] & 8'h18 & ~seed[15:8]));
			check(irq_pin_two, |(seed[7:0] & 8'h18 & seed[15:8]));
		end
		wr(ADDR_INT_RTE, 8'h10);
		wr(ADDR_INT_EN, 8'h18);
		wr(ADDR_FORMAT, 8'h00);
		check({irq_pin_one, irq_pin_two}, 2'b00);
		rdc(ADDR_INT_SRC, 8'h18, 8'h18);
		@(posedge clk_sys);
		#1;
		check({irq_pin_one, irq_pin_two}, 2'b11);
		rdc(ADDR_INT_SRC, 8'h18, 8'h00);
		wr(ADDR_INT_EN, 8'h00);
		$display("test interrupts done");
		for (int j = 0; j < 2; j++) begin
			wr(ADDR_FORMAT, j[0] ? 8'h04 : 8'h00);
			s = smp();
			push(s);
			rdc(ADDR_INT_SRC, 8'h80, 8'h80);
			rdc(ADDR_INT_SRC, 8'h80, 8'h80);
			burst_chk(s, j[0]);
			rdc(ADDR_INT_SRC, 8'h81, 8'h00);
		end
		push(smp());
		s = smp();
		push(s);
		rdc(ADDR_INT_SRC, 8'h81, 8'h81);
		fork
			burst_chk(s, 1'b1);
			begin
				repeat (3) @(posedge clk_sys);
				#1;
				check(smp_ready, 1'b0);
			end
		join
		$display("test bypass done");
		wr(ADDR_FORMAT, 8'h00);
		wr(ADDR_BUF_CTL, 8'h42);
		q.delete();
		fill(D + 3);
		q = q[0:D];
		rdc(ADDR_BUF_STS, 8'h3f, 8'(D + 1));
		rdc(ADDR_INT_SRC, 8'h83, 8'h83);
		drain();
		rdc(ADDR_INT_SRC, 8'h02, 8'h00);
		wr(ADDR_BUF_CTL, 8'h40);
		rdc(ADDR_INT_SRC, 8'h02, 8'h02);
		$display("test fifo done");
		wr(ADDR_BUF_CTL, 8'h82);
		fill(D + 3);
		s = smp();
		fork
			burst_chk(q[0], 1'b0);
			begin
				repeat (3) @(posedge clk_sys);
				push(s);
			end
		join
		q = q[D:$];
		q.push_back(s);
		drain();
		$display("test stream done");
		wr(ADDR_FORMAT, 8'h20);
		wr(ADDR_INT_RTE, 8'h10);
		wr(ADDR_INT_EN, 8'h10);
		wr(ADDR_BUF_CTL, 8'hc1);
		ev(1'b1, 1'b0);
		rdc(ADDR_BUF_STS, 8'h80, 8'h00);
		rdc(ADDR_INT_SRC, 8'h10, 8'h10);
		wr(ADDR_BUF_CTL, 8'he1);
		q.delete();
		fill(3);
		q.delete(1);
		rdc(ADDR_BUF_STS, 8'h3f, 8'h02);
		ev(1'b1, 1'b0);
		rdc(ADDR_BUF_STS, 8'h80, 8'h80);
		fill(D + 3);
		q = q[0:D];
		rdc(ADDR_BUF_STS, 8'h3f, 8'(D + 1));
		rdc(ADDR_INT_SRC, 8'h01, 8'h01);
		drain();
		$display("test trigger done");
		conclude();
	end
endmodule // testbench
